/* shared/mcs_pkg.sv */
// constants, types and the register layout of the motor command safety logic
package mcs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_MS = 500;
  localparam int PERIOD_NOENC_MS = 208;
  localparam int PERIOD_ENC_MS = 224;
  localparam int RAMP_STEP_US = 4000;
  localparam int REV_CHAR_MS = 500;
  localparam int BAUD = 9600;
  localparam int DEBOUNCE_CYC_DEF = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int PERIOD_NOENC_CYC_DEF = PERIOD_NOENC_MS * (CLK_HZ / 1000);
  localparam int PERIOD_ENC_CYC_DEF = PERIOD_ENC_MS * (CLK_HZ / 1000);
  localparam int RAMP_STEP_CYC_DEF = RAMP_STEP_US * (CLK_HZ / 1_000_000);
  localparam int REV_CHAR_CYC_DEF = REV_CHAR_MS * (CLK_HZ / 1000);
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int BOOT_CYC = 5;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [13:0] CFG_RESET = 14'h0007;
  localparam int CFG_TRIM_LSB = 0;
  localparam int CFG_CLOSED = 4;
  localparam int CFG_MIXED = 5;
  localparam int CFG_STOP_LSB = 6;
  localparam int CFG_AUXE_LSB = 8;
  localparam int CFG_AUXF_LSB = 10;
  localparam int CFG_BRAKE = 12;
  localparam int CFG_SWACC = 13;
  localparam int STS_ESTOP = 0;
  localparam int STS_INV = 1;
  localparam int STS_TEST = 2;
  localparam int STS_PWR = 3;
  localparam int STS_ENC = 4;

  // ---------------------------------------------------------------
  // trim decode
  // ---------------------------------------------------------------
  localparam logic [3:0] TRIM_NONE = 4'h7;
  localparam logic [3:0] TRIM_MAX = 4'he;
  localparam logic [8:0] TRIM_DEN = 9'h190; // 400: one step is 3/400
  localparam logic [8:0] TRIM_STEP = 9'h003;

  // ---------------------------------------------------------------
  // pin slots in the synchroniser vector
  // ---------------------------------------------------------------
  localparam int PIN_PROG = 0;
  localparam int PIN_SET = 1;
  localparam int PIN_STOP = 2;
  localparam int PIN_AUXE = 3;
  localparam int PIN_AUXF = 4;
  localparam int PIN_ENC = 5;
  localparam int NPIN = 6;

  // ---------------------------------------------------------------
  // self-test
  // ---------------------------------------------------------------
  localparam logic signed [7:0] RAMP_MAX = 8'sh7f;
  localparam logic [2:0] REV_LEN = 3'h5;
  // revision text shown low character first; value is arbitrary
  localparam logic [39:0] REV_TEXT = 40'h61_2d30_2d31; // "1-0-a"
  localparam logic [7:0] LED_BLANK = 8'h20;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [3:0] NVAL_NOENC = 4'hc;
  localparam logic [3:0] NVAL_ENC = 4'hd;

  typedef enum logic [1:0] {
    STOP_NONE = 2'h0,
    STOP_ESTOP = 2'h1,
    STOP_FLIP = 2'h2
  } mcs_stop_e;

  typedef enum logic [1:0] {
    AUX_NONE = 2'h0,
    AUX_ACC = 2'h1,
    AUX_DEADMAN = 2'h2
  } mcs_aux_e;

  typedef enum logic [7:0] {
    ST_RUN = 8'h01,
    ST_REV = 8'h02,
    ST_M1_UP = 8'h04,
    ST_M1_DN = 8'h08,
    ST_M1_RET = 8'h10,
    ST_M2_UP = 8'h20,
    ST_M2_DN = 8'h40,
    ST_M2_RET = 8'h80
  } mcs_st_e;

endpackage : mcs_pkg

/* hdl/mcs_motor_safety.sv */
// motor command conditioning, emergency stop, aux inputs and self-test sequencer
module mcs_motor_safety
  import mcs_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DEBOUNCE_CYC_DEF,
  parameter int PERIOD_NOENC_CYC = PERIOD_NOENC_CYC_DEF,
  parameter int PERIOD_ENC_CYC = PERIOD_ENC_CYC_DEF,
  parameter int RAMP_STEP_CYC = RAMP_STEP_CYC_DEF,
  parameter int REV_CHAR_CYC = REV_CHAR_CYC_DEF
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // operator pins, asynchronous
  input wire logic i_btn_prog,
  input wire logic i_btn_set,
  input wire logic i_stop_or_flip_switch_input,
  input wire logic i_aux_e,
  input wire logic i_aux_f,
  input wire logic i_encoder_fitted,
  // commands after the response curve, same clock
  input wire logic signed [7:0] i_cmd1,
  input wire logic signed [7:0] i_cmd2,
  // telemetry value source, same clock
  input wire logic [7:0] i_tlm_value,
  output logic [3:0] o_tlm_index,
  // power stage, display and serial
  output logic signed [7:0] o_drive1,
  output logic signed [7:0] o_drive2,
  output logic o_power_en,
  output logic o_accessory,
  output logic [7:0] o_led_char,
  output logic o_tx
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NPIN-1:0] sy1;
    logic [NPIN-1:0] sy2;
    logic [NPIN-1:0] sy3;
    logic [NPIN-1:0] pin;
    logic [2:0] boot;
    logic booted;
    logic [13:0] cfg;
    logic [31:0] rdata;
    logic estop;
    logic inv;
    logic [23:0] db_cnt;
    mcs_st_e st;
    logic [23:0] st_cnt;
    logic [2:0] rev_idx;
    logic signed [7:0] ramp;
    logic [23:0] per_cnt;
    logic sending;
    logic [4:0] ch_idx;
    logic [3:0] bit_idx;
    logic [11:0] baud_cnt;
    logic [9:0] sh;
    logic tx;
    logic [3:0] tidx;
    logic signed [7:0] drv1;
    logic signed [7:0] drv2;
    logic pwr;
    logic acc;
    logic [7:0] led;
  } mcs_state_s;

  mcs_state_s s;
  mcs_state_s next_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // scale the magnitude down on the slowed direction, not in closed loop; the output
  // cannot exceed full scale, so the favoured side is never boosted
  function automatic logic signed [7:0] apply_trim(input logic signed [7:0] cmd,
                                                   input logic [3:0] trim,
                                                   input logic closed);
    logic [6:0] mag;
    logic [3:0] k;
    logic slow;
    logic [15:0] prod;
    logic [6:0] res;
    mag = (cmd < 0) ? ((cmd == -8'sd128) ? 7'h7f : 7'(-cmd)) : 7'(cmd);
    k = 4'h0;
    slow = 1'b0;
    if (trim < TRIM_NONE)
    begin
      k = TRIM_NONE - trim;
      slow = (cmd > 0);
    end
    else if (trim > TRIM_NONE && trim <= TRIM_MAX)
    begin
      k = trim - TRIM_NONE;
      slow = (cmd < 0);
    end
    prod = 16'(mag) * 16'(TRIM_DEN - 9'(k) * TRIM_STEP);
    res = (slow && !closed) ? 7'(prod / 16'(TRIM_DEN)) : mag;
    apply_trim = (cmd < 0) ? -$signed({1'b0, res}) : $signed({1'b0, res});
  endfunction : apply_trim

  // ascii code of one hex digit
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? (8'h30 + 8'(nib)) : (8'h37 + 8'(nib));
  endfunction : hex_char

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // one combinational pass computes every register's next value
  always_comb
  begin
    logic [1:0] stop_mode;
    logic [1:0] auxe_mode;
    logic [1:0] auxf_mode;
    logic auxe_on;
    logic st_tick;
    logic flip;
    logic gate;
    logic acc_aux;
    logic [3:0] nval;
    logic [23:0] period;
    logic [7:0] ch;
    logic [7:0] val;
    logic signed [7:0] c1;
    logic signed [7:0] c2;
    next_s = s;
    stop_mode = s.cfg[CFG_STOP_LSB +: 2];
    auxe_mode = s.cfg[CFG_AUXE_LSB +: 2];
    auxf_mode = s.cfg[CFG_AUXF_LSB +: 2];
    auxe_on = !s.pin[PIN_ENC];
    nval = s.pin[PIN_ENC] ? NVAL_ENC : NVAL_NOENC;
    period = s.pin[PIN_ENC] ? 24'(PERIOD_ENC_CYC - 1) : 24'(PERIOD_NOENC_CYC - 1);
    ch = 8'h00;
    val = 8'h00;

    // pins: three stages, accept a level once the last two agree
    next_s.sy1 = {i_encoder_fitted, i_aux_f, i_aux_e, i_stop_or_flip_switch_input,
                  i_btn_set, i_btn_prog};
    next_s.sy2 = s.sy1;
    next_s.sy3 = s.sy2;
    if (s.sy2 == s.sy3)
    begin
      next_s.pin = s.sy3;
    end

    // register port; reads answer one cycle later, unmapped reads zero
    next_s.rdata = 32'h0000_0000;
    if (i_wr && i_addr == ADDR_CFG)
    begin
      next_s.cfg = i_wdata[13:0];
    end
    if (i_rd && i_addr == ADDR_CFG)
    begin
      next_s.rdata = {18'h0_0000, s.cfg};
    end
    else if (i_rd && i_addr == ADDR_STATUS)
    begin
      next_s.rdata[STS_ESTOP] = s.estop;
      next_s.rdata[STS_INV] = s.inv;
      next_s.rdata[STS_TEST] = (s.st != ST_RUN);
      next_s.rdata[STS_PWR] = s.pwr;
      next_s.rdata[STS_ENC] = s.pin[PIN_ENC];
    end

    // emergency stop: set-only, cleared by reset alone
    if (s.booted && s.pin[PIN_PROG] && s.pin[PIN_SET])
    begin
      next_s.estop = 1'b1;
    end
    if (stop_mode == STOP_ESTOP && s.pin[PIN_STOP])
    begin
      next_s.estop = 1'b1;
    end

    // flip switch debounce; any bounce restarts the count
    if (s.pin[PIN_STOP] == s.inv)
    begin
      next_s.db_cnt = 24'h00_0000;
    end
    else if (s.db_cnt == 24'(DEBOUNCE_CYC - 1))
    begin
      next_s.db_cnt = 24'h00_0000;
      next_s.inv = s.pin[PIN_STOP];
    end
    else
    begin
      next_s.db_cnt = s.db_cnt + 24'h00_0001;
    end

    // wait for the pin pipeline to settle, then sample set once
    if (!s.booted)
    begin
      next_s.boot = s.boot + 3'h1;
      if (s.boot == 3'(BOOT_CYC - 1))
      begin
        next_s.booted = 1'b1;
        if (s.pin[PIN_SET])
        begin
          next_s.st = ST_REV;
          next_s.st_cnt = 24'h00_0000;
          next_s.rev_idx = 3'h0;
        end
      end
    end

    // self-test sequencer
    st_tick = 1'b0;
    if (s.st != ST_RUN)
    begin
      if ((s.st == ST_REV && s.st_cnt == 24'(REV_CHAR_CYC - 1)) ||
          (s.st != ST_REV && s.st_cnt == 24'(RAMP_STEP_CYC - 1)))
      begin
        st_tick = 1'b1;
        next_s.st_cnt = 24'h00_0000;
      end
      else
      begin
        next_s.st_cnt = s.st_cnt + 24'h00_0001;
      end
    end
    case (s.st)
      ST_RUN:
      begin
        next_s.led = LED_BLANK;
      end
      ST_REV:
      begin
        next_s.ramp = 8'sh00;
        next_s.led = REV_TEXT[8*s.rev_idx +: 8];
        if (st_tick)
        begin
          next_s.rev_idx = s.rev_idx + 3'h1;
          if (s.rev_idx == REV_LEN - 3'h1)
          begin
            next_s.rev_idx = 3'h0;
            next_s.led = LED_BLANK;
            next_s.st = ST_M1_UP;
          end
        end
      end
      ST_M1_UP, ST_M2_UP:
      begin
        if (st_tick)
        begin
          next_s.ramp = s.ramp + 8'sh01;
          if (s.ramp == RAMP_MAX - 8'sh01)
          begin
            next_s.st = (s.st == ST_M1_UP) ? ST_M1_DN : ST_M2_DN;
          end
        end
      end
      ST_M1_DN, ST_M2_DN:
      begin
        if (st_tick)
        begin
          next_s.ramp = s.ramp - 8'sh01;
          if (s.ramp == -RAMP_MAX + 8'sh01)
          begin
            next_s.st = (s.st == ST_M1_DN) ? ST_M1_RET : ST_M2_RET;
          end
        end
      end
      ST_M1_RET, ST_M2_RET:
      begin
        if (st_tick)
        begin
          next_s.ramp = s.ramp + 8'sh01;
          if (s.ramp == -8'sh01)
          begin
            next_s.st = (s.st == ST_M1_RET) ? ST_M2_UP : ST_REV;
          end
        end
      end
      default:
      begin
        next_s.st = ST_RUN;
      end
    endcase

    // motor drive: curve output, trim, flip, then the override chain
    c1 = apply_trim(i_cmd1, s.cfg[CFG_TRIM_LSB +: 4], s.cfg[CFG_CLOSED]);
    c2 = apply_trim(i_cmd2, s.cfg[CFG_TRIM_LSB +: 4], s.cfg[CFG_CLOSED]);
    flip = s.cfg[CFG_MIXED] && stop_mode == STOP_FLIP && s.inv;
    if (flip)
    begin
      c1 = -c1;
      c2 = -c2;
    end
    if (s.st != ST_RUN)
    begin
      c1 = (s.st == ST_M1_UP || s.st == ST_M1_DN || s.st == ST_M1_RET) ? s.ramp : 8'sh00;
      c2 = (s.st == ST_M2_UP || s.st == ST_M2_DN || s.st == ST_M2_RET) ? s.ramp : 8'sh00;
    end
    // the newly latched stop is used so drive drops on the same edge
    next_s.drv1 = next_s.estop ? 8'sh00 : c1;
    next_s.drv2 = next_s.estop ? 8'sh00 : c2;

    // power transistors: dead-man gates, stop overrides all
    gate = 1'b1;
    if (auxe_on && auxe_mode == AUX_DEADMAN && s.pin[PIN_AUXE])
    begin
      gate = 1'b0;
    end
    if (auxf_mode == AUX_DEADMAN && s.pin[PIN_AUXF])
    begin
      gate = 1'b0;
    end
    next_s.pwr = gate && !next_s.estop;

    // accessory output; idle aux modes contribute nothing
    acc_aux = (auxe_on && auxe_mode == AUX_ACC && !s.pin[PIN_AUXE]) ||
              (auxf_mode == AUX_ACC && !s.pin[PIN_AUXF]);
    next_s.acc = s.cfg[CFG_SWACC] || acc_aux ||
                 (s.cfg[CFG_BRAKE] && (s.drv1 != 8'sh00 || s.drv2 != 8'sh00));

    // telemetry period; a string in flight is never cut short
    if (s.st == ST_RUN)
    begin
      next_s.per_cnt = 24'h00_0000;
    end
    else if (s.per_cnt == period)
    begin
      next_s.per_cnt = 24'h00_0000;
      if (!s.sending)
      begin
        next_s.sending = 1'b1;
        next_s.ch_idx = 5'h00;
        next_s.tidx = 4'h0;
        next_s.bit_idx = 4'h0;
        next_s.baud_cnt = 12'h000;
      end
    end
    else
    begin
      next_s.per_cnt = s.per_cnt + 24'h00_0001;
    end

    // serial 8N1: two hex characters per value, then a carriage return
    val = i_tlm_value;
    if (s.ch_idx == {nval, 1'b0})
    begin
      ch = CHAR_CR;
    end
    else
    begin
      ch = hex_char(s.ch_idx[0] ? val[3:0] : val[7:4]);
    end
    if (s.sending)
    begin
      if (s.bit_idx == 4'h0 && s.baud_cnt == 12'h000)
      begin
        next_s.sh = {1'b1, ch, 1'b0};
        next_s.tx = 1'b0;
        next_s.bit_idx = 4'h1;
        next_s.baud_cnt = 12'(BIT_CYC - 1);
        next_s.tidx = 4'((s.ch_idx + 5'h01) >> 1);
      end
      else if (s.baud_cnt != 12'h000)
      begin
        next_s.baud_cnt = s.baud_cnt - 12'h001;
      end
      else if (s.bit_idx == 4'ha)
      begin
        next_s.bit_idx = 4'h0;
        next_s.ch_idx = s.ch_idx + 5'h01;
        if (s.ch_idx == {nval, 1'b0})
        begin
          next_s.sending = 1'b0;
          next_s.tidx = 4'h0;
        end
      end
      else
      begin
        next_s.tx = s.sh[s.bit_idx];
        next_s.bit_idx = s.bit_idx + 4'h1;
        next_s.baud_cnt = (s.bit_idx == 4'h9) ? 12'h000 : 12'(BIT_CYC - 1);
        if (s.bit_idx == 4'h9)
        begin
          next_s.baud_cnt = 12'(BIT_CYC - 1);
        end
      end
    end
    else
    begin
      next_s.tx = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // every field resets to a constant; straps are sampled after release
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.st <= ST_RUN;
      s.tx <= 1'b1;
      s.led <= LED_BLANK;
      s.pwr <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rdata = s.rdata;
  assign o_tlm_index = s.tidx;
  assign o_drive1 = s.drv1;
  assign o_drive2 = s.drv2;
  assign o_power_en = s.pwr;
  assign o_accessory = s.acc;
  assign o_led_char = s.led;
  assign o_tx = s.tx;

endmodule : mcs_motor_safety

/* test/mcs_serial_monitor.sv */
// far-side serial monitor that decodes the telemetry line
module mcs_serial_monitor
  import mcs_pkg::*;
(
  // clock and serial line
  input wire logic i_clk,
  input wire logic i_rx,
  // decoded characters
  output logic [7:0] o_byte,
  output int o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  // ------------------------
  // 8n1 receiver
  // ------------------------
  // nothing is captured before the first start bit
  initial
  begin
    o_byte = 8'h00;
    o_count = 0;
  end
  // sample mid-bit, lsb first; wait to mid stop bit so a data low is never a start
  always
  begin
    @(negedge i_rx);
    repeat (BIT_CYC / 2) @(posedge i_clk);
    for (int b = 0; b < 8; b++)
    begin
      repeat (BIT_CYC) @(posedge i_clk);
      sh[b] = i_rx;
    end
    repeat (BIT_CYC) @(posedge i_clk);
    o_byte = sh;
    o_count++;
  end
endmodule : mcs_serial_monitor

/* test/mcs_motor_safety_asserts.sv */
// port-level checker for the motor command safety logic
module mcs_motor_safety_asserts
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // operator pins and commands
  input wire logic i_btn_prog,
  input wire logic i_btn_set,
  input wire logic i_stop_or_flip_switch_input,
  input wire logic i_aux_f,
  input wire logic signed [7:0] i_cmd1,
  // outputs
  input wire logic signed [7:0] o_drive1,
  input wire logic signed [7:0] o_drive2,
  input wire logic o_power_en,
  input wire logic o_accessory,
  input wire logic o_tx
);
  logic [13:0] cfg;
  logic [2:0] boot;
  logic strap;
  logic any_stop;
  logic [3:0] both_cnt;
  // ------------------------
  // shadow state
  // ------------------------
  // cfg copy, boot count, strap and stop history seen from the pins
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cfg <= CFG_RESET;
      boot <= 3'h0;
      strap <= 1'b0;
      any_stop <= 1'b0;
      both_cnt <= 4'h0;
    end
    else
    begin
      if (i_wr && i_addr == ADDR_CFG)
        cfg <= i_wdata[13:0];
      if (boot != 3'h7)
        boot <= boot + 3'h1;
      if (boot == 3'h2)
        strap <= i_btn_set;
      if ((i_btn_prog && i_btn_set) || (cfg[7:6] == 2'h1 && i_stop_or_flip_switch_input))
        any_stop <= 1'b1;
      // saturates at 8, so a full press stays remembered
      if (boot == 3'h7 && i_btn_prog && i_btn_set && both_cnt != 4'h8)
        both_cnt <= both_cnt + 4'h1;
      else if (both_cnt != 4'h8)
        both_cnt <= 4'h0;
    end
  end
  // ------------------------
  // properties
  // ------------------------
  a_rdata_idle: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !$past(i_rd) |-> o_rdata == 32'h0000_0000) else $error("read data not idle");
  a_unmapped_read: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    $past(i_rd) && $past(i_addr) != ADDR_CFG && $past(i_addr) != ADDR_STATUS
    |-> o_rdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_cfg_readback: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    $past(i_rd) && $past(i_addr) == ADDR_CFG |-> o_rdata == {18'h0_0000, $past(cfg)})
    else $error("config readback wrong");
  a_closed_bypass: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    $past(cfg[4]) && $past(cfg[7:6]) == 2'h0 && !strap && !any_stop
    && $past(i_cmd1) != 8'sh80 |-> o_drive1 == $past(i_cmd1))
    else $error("closed loop command altered");
  a_stop_latched: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    both_cnt == 4'h8 |-> o_drive1 == 8'sh00 && o_drive2 == 8'sh00 && !o_power_en)
    else $error("stop not held");
  a_full_scale: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_drive1 != 8'sh80 && o_drive2 != 8'sh80) else $error("drive past full scale");
  a_aux_acc: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg[11:10] == 2'h1 && !i_aux_f)[*8] |-> o_accessory)
    else $error("accessory not on");
  a_dead_man: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (cfg[11:10] == 2'h2 && i_aux_f)[*8] |-> !o_power_en)
    else $error("power stage not off");
  a_start_bit: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    $fell(o_tx) |-> (!o_tx)[*8]) else $error("start bit too short");
  a_tx_quiet: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    boot == 3'h7 && !strap |-> o_tx) else $error("serial busy outside self-test");
endmodule : mcs_motor_safety_asserts

bind mcs_motor_safety mcs_motor_safety_asserts mcs_motor_safety_asserts_inst (
  .i_mclk(i_mclk),
  .i_arst_n(i_arst_n),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_btn_prog(i_btn_prog),
  .i_btn_set(i_btn_set),
  .i_stop_or_flip_switch_input(i_stop_or_flip_switch_input),
  .i_aux_f(i_aux_f),
  .i_cmd1(i_cmd1),
  .o_drive1(o_drive1),
  .o_drive2(o_drive2),
  .o_power_en(o_power_en),
  .o_accessory(o_accessory),
  .o_tx(o_tx)
);

/* test/mcs_motor_safety_tb.sv */
// self-checking bench for the motor command safety logic
module mcs_motor_safety_tb
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic prog = 1'b0;
  logic set_b = 1'b0;
  logic sw = 1'b0;
  logic aux_e = 1'b1;
  logic aux_f = 1'b1;
  logic enc = 1'b0;
  logic signed [7:0] c1 = 8'sh00;
  logic signed [7:0] c2 = 8'sh00;
  logic [7:0] tval = 8'h5a;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [3:0] tidx;
  logic signed [7:0] d1;
  logic signed [7:0] d2;
  logic pwr;
  logic acc;
  logic tx;
  logic [7:0] led;
  logic [7:0] rx_byte;
  int rx_count;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  // short counts keep debounce, ramps and display within the run
  mcs_motor_safety #(.DEBOUNCE_CYC(20), .PERIOD_NOENC_CYC(3000), .PERIOD_ENC_CYC(3200),
    .RAMP_STEP_CYC(2), .REV_CHAR_CYC(4)) mcs_motor_safety_inst (
    .i_mclk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(we), .i_rd(re),
    .o_rdata(rdata), .i_btn_prog(prog), .i_btn_set(set_b), .i_stop_or_flip_switch_input(sw),
    .i_aux_e(aux_e), .i_aux_f(aux_f), .i_encoder_fitted(enc), .i_cmd1(c1), .i_cmd2(c2),
    .i_tlm_value(tval), .o_tlm_index(tidx), .o_drive1(d1), .o_drive2(d2), .o_power_en(pwr),
    .o_accessory(acc), .o_led_char(led), .o_tx(tx));
  mcs_serial_monitor mcs_serial_monitor_inst (.i_clk(clk), .i_rx(tx), .o_byte(rx_byte),
    .o_count(rx_count));

  // ------------------------
  // clock, timeout, helpers
  // ------------------------
  // 20 MHz
  always #25 clk = ~clk;
  // a hang is cut short and counted as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  task automatic apply(input logic signed [7:0] a, input logic signed [7:0] b);
    @(posedge clk);
    c1 <= a;
    c2 <= b;
    wait_cyc(1);
  endtask : apply
  // set button level across release chooses self-test or normal start
  task automatic do_reset(input logic strap);
    @(posedge clk);
    rst_n <= 1'b0;
    set_b <= strap;
    prog <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    set_b <= 1'b0;
    wait_cyc(4);
  endtask : do_reset
  task automatic aux_case(input logic [31:0] cf, input logic en, e, f, ea, ep);
    reg_wr(4'h0, cf);
    @(posedge clk);
    enc <= en;
    aux_e <= e;
    aux_f <= f;
    wait_cyc(8);
    check(acc, ea);
    check(pwr, ep);
  endtask : aux_case
  task automatic both_buttons();
    @(posedge clk);
    prog <= 1'b1;
    set_b <= 1'b1;
    wait_cyc(9);
    check(d1, 0);
    check(d2, 0);
    check(pwr, 0);
  endtask : both_buttons
  // trim reduces only the disfavoured direction, by 3/400 per step
  function automatic logic signed [7:0] trimmed(input int t, input int c);
    int m;
    int k;
    m = (c < 0) ? -c : c;
    k = (t < 7) ? 7 - t : t - 7;
    if ((t < 7 && c > 0) || (t > 7 && c < 0))
      m = m * (400 - 3 * k) / 400;
    return 8'((c < 0) ? -m : m);
  endfunction : trimmed

  // ------------------------
  // test sequence
  // ------------------------
  initial
  begin
    do_reset(1'b0);
    reg_rd(4'h0, d);
    check(d, 32'h0000_0007);
    reg_wr(4'h8, 32'h0000_1fff);
    reg_rd(4'h8, d);
    check(d, 32'h0000_0000);
    reg_rd(4'h0, d);
    check(d, 32'h0000_0007);
    reg_rd(4'h4, d);
    check(d, 32'h0000_0008);
    $display("test registers done");
    for (int t = 0; t < 15; t++)
    begin
      reg_wr(4'h0, 32'(t));
      apply(8'sd100, -8'sd100);
      check(d1, trimmed(t, 100));
      check(d2, trimmed(t, -100));
      apply(8'sd40, -8'sd127);
      check(d1, trimmed(t, 40));
      check(d2, trimmed(t, -127));
    end
    reg_wr(4'h0, 32'h0000_0010);
    apply(8'sd100, -8'sd100);
    check(d1, 100);
    check(d2, -100);
    $display("test trim done");
    reg_wr(4'h0, 32'h0000_0007);
    apply(8'sd50, 8'sd0);
    wait_cyc(2);
    check(acc, 0);
    reg_wr(4'h0, 32'h0000_1007);
    wait_cyc(2);
    check(acc, 1);
    apply(8'sd0, 8'sd0);
    wait_cyc(2);
    check(acc, 0);
    aux_case(32'h0000_0407, 0, 1, 0, 1, 1);
    aux_case(32'h0000_0407, 0, 1, 1, 0, 1);
    aux_case(32'h0000_0807, 0, 1, 1, 0, 0);
    aux_case(32'h0000_0807, 0, 1, 0, 0, 1);
    aux_case(32'h0000_0107, 1, 0, 1, 0, 1);
    aux_case(32'h0000_0107, 0, 0, 1, 1, 1);
    aux_case(32'h0000_0007, 0, 0, 0, 0, 1);
    $display("test accessory done");
    reg_wr(4'h0, 32'h0000_00a7);
    apply(8'sd40, -8'sd30);
    @(posedge clk) sw <= 1'b1;
    wait_cyc(10);
    @(posedge clk) sw <= 1'b0;
    wait_cyc(3);
    @(posedge clk) sw <= 1'b1;
    wait_cyc(15);
    check(d1, 40);
    wait_cyc(15);
    check(d1, -40);
    check(d2, 30);
    reg_wr(4'h0, 32'h0000_0087);
    wait_cyc(2);
    check(d1, 40);
    reg_wr(4'h0, 32'h0000_0007);
    wait_cyc(6);
    check(d1, 40);
    reg_wr(4'h0, 32'h0000_0047);
    wait_cyc(6);
    check(d1, 0);
    check(pwr, 0);
    @(posedge clk) sw <= 1'b0;
    wait_cyc(8);
    check(d1, 0);
    reg_rd(4'h4, d);
    check(d & 32'h0000_0009, 32'h0000_0001);
    $display("test switch done");
    do_reset(1'b0);
    check(d1, 40);
    both_buttons();
    @(posedge clk);
    prog <= 1'b0;
    set_b <= 1'b0;
    wait_cyc(8);
    check(d1, 0);
    $display("test buttons done");
    do_reset(1'b1);
    while (led !== 8'h31) wait_cyc(1);
    check(d1, 0);
    check(d2, 0);
    while (d1 !== 8'sh7f) wait_cyc(1);
    check(d2, 0);
    while (d1 !== -8'sh7f) wait_cyc(1);
    while (d2 !== 8'sh7f) wait_cyc(1);
    check(d1, 0);
    reg_rd(4'h4, d);
    check(d & 32'h0000_0004, 32'h0000_0004);
    while (rx_count == 0) wait_cyc(1);
    check(rx_byte, 8'h35);
    check(tidx, 4'h0);
    while (rx_count == 1) wait_cyc(1);
    check(rx_byte, 8'h41);
    check(tidx, 4'h1);
    both_buttons();
    wait_cyc(50);
    check(d1, 0);
    check(d2, 0);
    $display("test self-test done");
    give_verdict();
  end
endmodule : mcs_motor_safety_tb
